//--- vsc_regs.vh
// Register map, field layout and reset values of the interrupt source control.
// How it works
// [RQ1] Thirty-two maskable sources, eight levels, vectors.
// [RQ2] Drive fast and normal request lines.
// [RQ3] Internal sources level or edge, fixed polarity.
// [RQ4] External pins: rising, falling, high, low.
// [RQ5] Fast forcing routes a source to fast.
// [RQ6] Clock always runs, never gated.
// [RQ7] Either request asserted raises the wake event.
// [RQ8] General mask wakes without asserting request.
// [RQ9] Source 0 is the fast pin.
// [RQ10] Source 1 is OR of system lines.
// [RQ11] Sources 2 to 31 are peripheral or external.
// [RQ12] Per-source mode register selects trigger condition.
// [RQ13] Enable and disable commands; mask readable.
// [RQ14] Disabled source never affects other sources.
// [RQ15] Set and clear commands touch edge latches only.
// [RQ16] Software may set edge sources for test.
// [RQ17] Vector read clears current edge latch only.
// [RQ18] No vector-read clear for fast forced sources.
// [RQ19] Fast vector read clears source 0 latch.
// [RQ20] Pending shows activity unmasked; mask shows enables.
// [RQ21] Current source register returns serviced source.
// [RQ22] Core status shows both request line states.
// [RQ23] Priority 7 high; ties go to lowest number.
// [RQ24] Vector read selects, deasserts, pushes, returns vector.
// [RQ25] End of service pops and rearms request.
// [RQ26] Reset disables all and clears all latches.
`ifndef VSC_REGS_VH
`define VSC_REGS_VH
// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define VSC_AW 12
`define VSC_MODE_PAGE 5'h00
`define VSC_VEC_PAGE 5'h01
`define VSC_VECTOR_READ 12'h100
`define VSC_FAST_VECTOR_READ 12'h104
`define VSC_CURRENT_SOURCE 12'h108
`define VSC_PENDING_VIEW 12'h10c
`define VSC_ENABLE_MASK 12'h110
`define VSC_CORE_LINE_STATUS 12'h114
`define VSC_ENABLE_CMD 12'h120
`define VSC_DISABLE_CMD 12'h124
`define VSC_CLEAR_CMD 12'h128
`define VSC_SET_CMD 12'h12c
`define VSC_END_OF_SERVICE 12'h130
`define VSC_SPURIOUS_VECTOR 12'h134
`define VSC_GENERAL_MASK 12'h138
`define VSC_FORCE_ENABLE_CMD 12'h140
`define VSC_FORCE_DISABLE_CMD 12'h144
`define VSC_FORCE_STATUS 12'h148
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define VSC_PRIO_LSB 0
`define VSC_PRIO_MSB 2
`define VSC_TRIG_LSB 5
`define VSC_TRIG_MSB 6
`define VSC_STACK_DEPTH 4'h8
`define VSC_MASK_RESET 32'h0000_0000
`define VSC_VEC_RESET 32'h0000_0000
`endif

//--- vsc_top.v
// Source control, priority and vectoring of the interrupt controller.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "vsc_regs.vh"
module vsc_top #(
    parameter [31:0] EXT_SRC = 32'h6000_0001,
    parameter HAS_FAST_PIN = 1,
    parameter SYS_LINES = 4
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Register port
    input wire [`VSC_AW-1:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // Interrupt sources
    input wire fast_interrupt_pin,
    input wire [SYS_LINES-1:0] system_lines,
    input wire [31:2] peripheral_source_ids,
    // Processor core lines
    output reg normal_request_out_n,
    output reg fast_request_out_n,
    output reg wake_out
);

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------
reg [2:0] prio [0:31];
reg [1:0] trig [0:31];
reg [31:0] vec [0:31];
reg [31:0] spurious_vec;
reg [31:0] enable_mask;
reg [31:0] force_mask;
reg general_mask;
reg [2:0] stk_lvl [0:7];
reg [4:0] stk_src [0:7];
reg [3:0] depth;
// Each process keeps its own loop index, so no variable has two drivers.
integer i;
integer j;
integer k;

wire [4:0] page = addr[11:7];
wire [4:0] idx = addr[6:2];
wire wr_mode = wr && (page == `VSC_MODE_PAGE);
wire wr_vec = wr && (page == `VSC_VEC_PAGE);
wire wr_en = wr && (addr == `VSC_ENABLE_CMD);
wire wr_dis = wr && (addr == `VSC_DISABLE_CMD);
wire wr_set = wr && (addr == `VSC_SET_CMD);
wire wr_clr = wr && (addr == `VSC_CLEAR_CMD);
wire wr_eoi = wr && (addr == `VSC_END_OF_SERVICE);
wire wr_fen = wr && (addr == `VSC_FORCE_ENABLE_CMD);
wire wr_fdis = wr && (addr == `VSC_FORCE_DISABLE_CMD);
wire rd_ivr = rd && (addr == `VSC_VECTOR_READ);
wire rd_fvr = rd && (addr == `VSC_FAST_VECTOR_READ);

// ----------------------------------------------------------------
// Source wiring
// ----------------------------------------------------------------
wire src0 = (HAS_FAST_PIN != 0) ? fast_interrupt_pin : 1'b0; // see [RQ9]
wire src1 = |system_lines; // see [RQ10]
wire [31:0] src_raw = {peripheral_source_ids, src1, src0}; // see [RQ11]

// ----------------------------------------------------------------
// Priority search
// ----------------------------------------------------------------
wire [31:0] pend;
wire [31:0] act = pend & enable_mask; // see [RQ14]
wire [31:0] fast_act = act & (force_mask | 32'h0000_0001); // see [RQ5]
wire [31:0] norm_act = act & ~force_mask & 32'hffff_fffe;
wire [2:0] top_idx = depth[2:0] - 3'h1;
wire [2:0] cur_lvl = stk_lvl[top_idx];
reg win_found;
reg [4:0] win_src;
reg [2:0] win_prio;

// Strict compare while walking upward keeps the lowest number on ties.
always @* begin
    win_found = 1'b0;
    win_src = 5'h00;
    win_prio = 3'h0;
    for (i = 1; i < 32; i = i + 1) begin
        if (norm_act[i] && (!win_found || prio[i] > win_prio)) begin // see [RQ23]
            win_found = 1'b1;
            win_src = i[4:0];
            win_prio = prio[i];
        end
    end
end

// A level already in service never re-raises the line until it ends.
wire higher = win_found && ((depth == 4'h0) || (win_prio > cur_lvl)); // see [RQ1]
wire take = rd_ivr && higher;
wire push_ok = depth != `VSC_STACK_DEPTH;
wire [31:0] win_hot = 32'h0000_0001 << win_src;
wire [31:0] auto_clr = ((take ? win_hot : 32'h0000_0000) & ~force_mask) // see [RQ17] see [RQ18]
    | {31'h0, rd_fvr}; // see [RQ19]

// ----------------------------------------------------------------
// Per-source input stage
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 32; g = g + 1) begin : g_src
        wire lvl;
        reg prv;
        reg latch;
        if (EXT_SRC[g]) begin : g_ext
            reg s1;
            reg s2;
            always @(posedge ref_clk) begin
                if (rst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                end else begin
                    s1 <= src_raw[g];
                    s2 <= s1;
                end
            end
            assign lvl = s2;
        end else begin : g_int
            assign lvl = src_raw[g];
        end
        wire ext = EXT_SRC[g];
        wire is_edge = trig[g][0]; // see [RQ12]
        wire rise = lvl & ~prv;
        wire fall = ~lvl & prv;
        wire edge_hit = (ext && !trig[g][1]) ? fall : rise; // see [RQ4] see [RQ3]
        wire level_hit = (ext && !trig[g][0] && !trig[g][1]) ? ~lvl : lvl;
        wire set_ev = is_edge & (edge_hit | (wr_set & wdata[g])); // see [RQ15] see [RQ16]
        wire clr_ev = is_edge & ((wr_clr & wdata[g]) | auto_clr[g]);
        // Set wins over clear so an edge landing on a clear is kept.
        always @(posedge ref_clk) begin
            if (rst) begin
                prv <= 1'b0;
                latch <= 1'b0; // see [RQ26]
            end else begin
                prv <= lvl;
                latch <= (latch & ~clr_ev) | set_ev;
            end
        end
        assign pend[g] = is_edge ? latch : level_hit; // see [RQ20]
    end
endgenerate

// ----------------------------------------------------------------
// Configuration writes
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (rst) begin
        for (j = 0; j < 32; j = j + 1) begin
            prio[j] <= 3'h0;
            trig[j] <= 2'h0;
            vec[j] <= `VSC_VEC_RESET;
        end
        spurious_vec <= `VSC_VEC_RESET;
        enable_mask <= `VSC_MASK_RESET; // see [RQ26]
        force_mask <= `VSC_MASK_RESET;
        general_mask <= 1'b0;
    end else begin
        if (wr_mode) begin // see [RQ12]
            prio[idx] <= wdata[`VSC_PRIO_MSB:`VSC_PRIO_LSB];
            trig[idx] <= wdata[`VSC_TRIG_MSB:`VSC_TRIG_LSB];
        end
        if (wr_vec) begin
            vec[idx] <= wdata;
        end
        if (wr && addr == `VSC_SPURIOUS_VECTOR) begin
            spurious_vec <= wdata;
        end
        if (wr && addr == `VSC_GENERAL_MASK) begin
            general_mask <= wdata[0];
        end
        if (wr_en) begin
            enable_mask <= enable_mask | wdata; // see [RQ13]
        end
        if (wr_dis) begin
            enable_mask <= enable_mask & ~wdata;
        end
        if (wr_fen) begin
            force_mask <= force_mask | wdata;
        end
        if (wr_fdis) begin
            force_mask <= force_mask & ~wdata;
        end
    end
end

// ----------------------------------------------------------------
// Service stack
// ----------------------------------------------------------------
// A full stack refuses the push rather than overwrite a saved level.
always @(posedge ref_clk) begin
    if (rst) begin
        depth <= 4'h0;
        for (k = 0; k < 8; k = k + 1) begin
            stk_lvl[k] <= 3'h0;
            stk_src[k] <= 5'h00;
        end
    end else if (take && push_ok) begin // see [RQ24]
        stk_lvl[depth[2:0]] <= win_prio;
        stk_src[depth[2:0]] <= win_src;
        depth <= depth + 4'h1;
    end else if (wr_eoi && depth != 4'h0) begin // see [RQ25]
        depth <= depth - 4'h1;
    end
end

// ----------------------------------------------------------------
// Request lines
// ----------------------------------------------------------------
// Lines are registered, so a vector read drops the line one edge later.
wire norm_cond = higher & ~take;
wire fast_cond = |fast_act;

always @(posedge ref_clk) begin
    if (rst) begin
        normal_request_out_n <= 1'b1;
        fast_request_out_n <= 1'b1;
        wake_out <= 1'b0;
    end else begin
        normal_request_out_n <= ~(norm_cond & ~general_mask); // see [RQ2] see [RQ8]
        fast_request_out_n <= ~(fast_cond & ~general_mask);
        wake_out <= norm_cond | fast_cond; // see [RQ7]
    end
end

// ----------------------------------------------------------------
// Read port
// ----------------------------------------------------------------
wire [4:0] cur_src = (depth == 4'h0) ? 5'h00 : stk_src[top_idx];
reg [31:0] next_rdata;

always @* begin
    next_rdata = 32'h0000_0000;
    if (page == `VSC_MODE_PAGE) begin
        next_rdata[`VSC_PRIO_MSB:`VSC_PRIO_LSB] = prio[idx];
        next_rdata[`VSC_TRIG_MSB:`VSC_TRIG_LSB] = trig[idx];
    end else if (page == `VSC_VEC_PAGE) begin
        next_rdata = vec[idx];
    end else begin
        case (addr)
            `VSC_VECTOR_READ: next_rdata = higher ? vec[win_src] : spurious_vec;
            `VSC_FAST_VECTOR_READ: next_rdata = fast_cond ? vec[0] : spurious_vec;
            `VSC_CURRENT_SOURCE: next_rdata = {27'h0, cur_src}; // see [RQ21]
            `VSC_PENDING_VIEW: next_rdata = pend;
            `VSC_ENABLE_MASK: next_rdata = enable_mask;
            `VSC_CORE_LINE_STATUS: next_rdata = {30'h0, ~fast_request_out_n,
                ~normal_request_out_n}; // see [RQ22]
            `VSC_SPURIOUS_VECTOR: next_rdata = spurious_vec;
            `VSC_GENERAL_MASK: next_rdata = {31'h0, general_mask};
            `VSC_FORCE_STATUS: next_rdata = force_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end
end

// Runs on the free clock; no power control reaches this block.
always @(posedge ref_clk) begin // see [RQ6]
    if (rst) begin
        rdata <= 32'h0000_0000;
    end else if (rd) begin
        rdata <= next_rdata;
    end else begin
        rdata <= 32'h0000_0000;
    end
end

endmodule // vsc_top
`default_nettype wire

//--- vsc_src_model.sv
// Model of the peripheral lines and pins feeding the source control.
`timescale 1ns/1ps
`default_nettype none
module vsc_src_model (
    // Clock and requested line levels
    input wire logic ref_clk,
    input wire logic [31:0] want,
    // Source lines
    output logic fast_interrupt_pin,
    output logic [3:0] system_lines,
    output logic [31:2] peripheral_source_ids
);
    logic [31:0] q = 32'h0;
    // Lines move one edge after the request, like a registered peripheral.
    always @(posedge ref_clk) begin
        q <= want;
    end
    assign fast_interrupt_pin = q[0];
    assign system_lines = {1'b0, q[1], 2'b00};
    assign peripheral_source_ids = q[31:2];
endmodule // vsc_src_model
`default_nettype wire

//--- vsc_checker.sv
// Checker of the request lines and read port of the source control.
`timescale 1ns/1ps
`default_nettype none
`include "vsc_regs.vh"
module vsc_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [`VSC_AW-1:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Core lines
    input wire logic normal_request_out_n,
    input wire logic fast_request_out_n,
    input wire logic wake_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg unconfigured;
    always @(posedge ref_clk) begin
        if (rst) unconfigured <= 1'b1;
        else if (wr) unconfigured <= 1'b0;
    end
    property p_rst_lines; disable iff (1'b0)
        rst |=> normal_request_out_n && fast_request_out_n && !wake_out;
    endproperty
    a_rst_lines: assert property (p_rst_lines) else $error("lines busy");
    property p_rst_rdata; disable iff (1'b0) rst |=> rdata == 32'h0; endproperty
    a_rst_rdata: assert property (p_rst_rdata) else $error("rdata set");
    property p_quiet;
        unconfigured |-> normal_request_out_n && fast_request_out_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("early request");
    property p_wake; !normal_request_out_n || !fast_request_out_n |-> wake_out;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_idle; !rd |=> rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray rdata");
    property p_vec;
        rd && addr == `VSC_VECTOR_READ |-> ##[1:2] normal_request_out_n;
    endproperty
    a_vec: assert property (p_vec) else $error("request kept");
    property p_core; rd && addr == `VSC_CORE_LINE_STATUS |=> rdata[1:0] ==
        ~{$past(fast_request_out_n), $past(normal_request_out_n)};
    endproperty
    a_core: assert property (p_core) else $error("core status");
    property p_unmapped; rd && addr == 12'h200 |=> rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
endmodule // vsc_checker
bind vsc_top vsc_checker vsc_checker_i (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .normal_request_out_n(normal_request_out_n),
    .fast_request_out_n(fast_request_out_n), .wake_out(wake_out));
`default_nettype wire

//--- vsc_bench.sv
// Self-checking bench of the interrupt source control.
`timescale 1ns/1ps
`default_nettype none
`include "vsc_regs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module vsc_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] want = 32'h0;
    wire [31:0] rdata;
    wire normal_request_out_n, fast_request_out_n, wake_out, fpin;
    wire [3:0] system_combined_source;
    wire [31:2] per;
    wire [2:0] lines = {wake_out, fast_request_out_n, normal_request_out_n};
    int checked = 0;
    int fail_count = 0;
    int m;
    always #50 ref_clk = ~ref_clk;
    vsc_src_model vsc_src_model_i (.ref_clk(ref_clk), .want(want),
        .fast_interrupt_pin(fpin), .system_lines(system_combined_source),
        .peripheral_source_ids(per));
    vsc_top vsc_top_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fast_interrupt_pin(fpin), .system_lines(system_combined_source),
        .peripheral_source_ids(per), .wake_out(wake_out),
        .normal_request_out_n(normal_request_out_n),
        .fast_request_out_n(fast_request_out_n));
    // --------------------------------------------------------------
    // Bus tasks
    // --------------------------------------------------------------
    task automatic w(input [11:0] a, input [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic r(input [11:0] a, input [31:0] e, input string n);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        `CHK(n, e, rdata)
        @(posedge ref_clk);
    endtask
    // Waits for {wake, fast_n, normal_n}; a missed pattern ends the run.
    task automatic wt(input [2:0] e);
        int n;
        #1;
        for (n = 0; n < 30 && lines !== e; n++) @(posedge ref_clk) #1;
        `CHK("lines", e, lines)
        if (n == 30) report_and_stop();
        // Return on an edge so the next request starts right after it.
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop();
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        r(`VSC_ENABLE_MASK, 32'h0, "mask");
        // Pins reset to low-level mode read pending while idle low.
        r(`VSC_PENDING_VIEW, 32'h6000_0001, "pend");
        w(12'h000, 32'h40);
        w(12'h074, 32'h40);
        w(12'h078, 32'h40);
        r(`VSC_PENDING_VIEW, 32'h0, "pend");
        w(12'h200, 32'hffff_ffff);
        r(12'h200, 32'h0, "unmapped");
        w(`VSC_ENABLE_CMD, 32'h0000_0f0c);
        w(`VSC_DISABLE_CMD, 32'h0000_0f04);
        r(`VSC_ENABLE_MASK, 32'h8, "mask");
        w(`VSC_DISABLE_CMD, 32'hffff_ffff);
        $display("test masks done");
        w(12'h014, 32'h3);
        w(12'h094, 32'h55);
        want <= 32'h22;
        repeat (4) @(posedge ref_clk);
        wt(3'b011);
        r(`VSC_PENDING_VIEW, 32'h22, "pend");
        w(`VSC_ENABLE_CMD, 32'h20);
        wt(3'b110);
        r(`VSC_CORE_LINE_STATUS, 32'h1, "core");
        r(`VSC_VECTOR_READ, 32'h55, "vec");
        r(`VSC_CURRENT_SOURCE, 32'h5, "cur");
        w(`VSC_END_OF_SERVICE, 32'h0);
        wt(3'b110);
        want <= 32'h0;
        wt(3'b011);
        $display("test level done");
        w(12'h018, 32'h22);
        w(12'h01c, 32'h22);
        w(12'h098, 32'h66);
        w(12'h09c, 32'h77);
        w(`VSC_SET_CMD, 32'hc0);
        w(`VSC_CLEAR_CMD, 32'h80);
        w(`VSC_SET_CMD, 32'h20);
        r(`VSC_PENDING_VIEW, 32'h40, "pend");
        w(`VSC_SET_CMD, 32'h80);
        w(`VSC_ENABLE_CMD, 32'hc0);
        wt(3'b110);
        r(`VSC_VECTOR_READ, 32'h66, "vec");
        r(`VSC_PENDING_VIEW, 32'h80, "pend");
        w(`VSC_END_OF_SERVICE, 32'h0);
        r(`VSC_VECTOR_READ, 32'h77, "vec");
        w(`VSC_END_OF_SERVICE, 32'h0);
        w(`VSC_GENERAL_MASK, 32'h1);
        w(`VSC_SET_CMD, 32'h40);
        wt(3'b111);
        w(`VSC_GENERAL_MASK, 32'h0);
        r(`VSC_VECTOR_READ, 32'h66, "vec");
        w(`VSC_END_OF_SERVICE, 32'h0);
        $display("test edge done");
        w(`VSC_SPURIOUS_VECTOR, 32'h5a);
        w(12'h080, 32'hf0);
        w(`VSC_FORCE_ENABLE_CMD, 32'h80);
        w(`VSC_SET_CMD, 32'h80);
        wt(3'b101);
        r(`VSC_VECTOR_READ, 32'h5a, "vec");
        r(`VSC_PENDING_VIEW, 32'h80, "pend");
        w(`VSC_FORCE_DISABLE_CMD, 32'h80);
        w(`VSC_CLEAR_CMD, 32'h80);
        w(12'h000, 32'h60);
        w(`VSC_ENABLE_CMD, 32'h1);
        want <= 32'h1;
        wt(3'b101);
        want <= 32'h0;
        r(`VSC_FAST_VECTOR_READ, 32'hf0, "fvec");
        r(`VSC_PENDING_VIEW, 32'h0, "pend");
        wt(3'b011);
        $display("test fast done");
        // Pins pass a two-flop synchroniser, so each step waits four edges.
        for (m = 0; m < 4; m++) begin
            want <= {2'b00, ~m[1], 29'h0};
            w(12'h074, {25'h0, m[1:0], 5'h0});
            w(`VSC_CLEAR_CMD, 32'h2000_0000);
            want <= {2'b00, m[1], 29'h0};
            repeat (4) @(posedge ref_clk);
            r(`VSC_PENDING_VIEW, 32'h2000_0000, "pend");
            want <= {2'b00, ~m[1], 29'h0};
            repeat (4) @(posedge ref_clk);
            r(`VSC_PENDING_VIEW, {2'b00, m[0], 29'h0}, "pend");
        end
        $display("test pins done");
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        r(`VSC_ENABLE_MASK, 32'h0, "mask");
        $display("test reset again done");
        report_and_stop();
    end
endmodule // vsc_bench
`default_nettype wire
